/* File: rtl/ctpc_defines.vh */
// ======================================================================
// What this block does
// RQ1: read-select bit picks block for paged reads
// RQ2: write-enable bit gates paged register writes
// RQ3: one write updates every write-enabled block
// RQ4: control register paged; access routed by selection
// RQ5: calibration enable sends skew sequence before data
// RQ6: host should enable calibration at top rate
// RQ7: lane field selects four, three, two, one
// RQ8: lp00 field forces data or data plus clock
// RQ9: continuous clock only after first packet sent
// RQ10: output enable bit switches serial output
// RQ11: host stops forwarding before toggling output enable
// RQ12: reserved lp00 code acts as normal operation
`ifndef CTPC_DEFINES_VH
`define CTPC_DEFINES_VH

// ======================================================================
// register offsets
`define CTPC_PAGE_OFF 8'h32
`define CTPC_CTL_OFF 8'h33

// ======================================================================
// reset values and masks
`define CTPC_PAGE_RST 8'h00
`define CTPC_CTL_RST 8'h00
`define CTPC_PAGE_WMASK 8'h13
`define CTPC_CTL_WMASK 8'h7f

// ======================================================================
// page-select fields
`define CTPC_PAGE_RDSEL 4

// ======================================================================
// control fields
`define CTPC_CTL_CAL 6
`define CTPC_CTL_LANE_HI 5
`define CTPC_CTL_LANE_LO 4
`define CTPC_CTL_LP_HI 3
`define CTPC_CTL_LP_LO 2
`define CTPC_CTL_CONT 1
`define CTPC_CTL_EN 0

// ======================================================================
// lp00 force codes
`define CTPC_LP_NORMAL 2'h0
`define CTPC_LP_DATA 2'h1
`define CTPC_LP_RSVD 2'h2
`define CTPC_LP_ALL 2'h3

// ======================================================================
// block structure
`define CTPC_NUM_TX 2

`endif

/* File: rtl/ctpc_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "ctpc_defines.vh"

module ctpc_top #(
   parameter [6:0] I2C_ADDR = 7'h30 // target address, plain default
) (
   input wire i_core_clk,
   input wire i_arst_n,
   input wire i_scl,
   input wire i_sda_in,
   output wire o_sda_out,
   output wire o_sda_oe,
   input wire [`CTPC_NUM_TX-1:0] i_cal_done,
   input wire [`CTPC_NUM_TX-1:0] i_pkt_sent,
   output wire [`CTPC_NUM_TX-1:0] o_tx_on,
   output wire [`CTPC_NUM_TX-1:0] o_skew_cal,
   output wire [`CTPC_NUM_TX-1:0] o_hs_ok,
   output wire [4*`CTPC_NUM_TX-1:0] o_lane_en,
   output wire [`CTPC_NUM_TX-1:0] o_lp00_data,
   output wire [`CTPC_NUM_TX-1:0] o_lp00_clk,
   output wire [`CTPC_NUM_TX-1:0] o_cont_clk
);

   // ===================================================================
   // reset release
   reg [1:0] rst_sync_ff; // two-stage release of async reset
   wire rst_n; // synchronised reset used everywhere below

   // async assert, clocked release to avoid recovery hazards
   always @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // ===================================================================
   // pin synchronisers and edge detection
   reg [2:0] scl_ff; // [0] meta stage, [1] synced, [2] history
   reg [2:0] sda_ff; // same for data line
   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;

   // only stage [0] feeds stage [1]; logic looks at [1] and [2]
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_ff <= 3'h7;
         sda_ff <= 3'h7;
      end else begin
         scl_ff <= {scl_ff[1:0], i_scl};
         sda_ff <= {sda_ff[1:0], i_sda_in};
      end
   end
   assign scl_rise = scl_ff[1] & ~scl_ff[2];
   assign scl_fall = ~scl_ff[1] & scl_ff[2];
   assign bus_start = scl_ff[1] & scl_ff[2] & ~sda_ff[1] & sda_ff[2];
   assign bus_stop = scl_ff[1] & scl_ff[2] & sda_ff[1] & ~sda_ff[2];

   // ===================================================================
   // i2c target state machine
   localparam [2:0] ST_IDLE = 3'h0; // waiting for start
   localparam [2:0] ST_ADDR = 3'h1; // address and direction byte
   localparam [2:0] ST_ACKA = 3'h2; // acking own address
   localparam [2:0] ST_WR = 3'h3; // receiving pointer or data
   localparam [2:0] ST_ACKW = 3'h4; // acking received byte
   localparam [2:0] ST_RD = 3'h5; // shifting out read data
   localparam [2:0] ST_MACK = 3'h6; // controller ack after read

   reg [2:0] i2c_st_ff; // target state
   reg [3:0] bit_cnt_ff; // bits seen in current byte
   reg [7:0] shift_ff; // byte shift register
   reg rw_ff; // 1 while a read transfer runs
   reg ptr_pending_ff; // next written byte is the pointer
   reg [7:0] ptr_ff; // register pointer, auto-increments
   reg sda_oe_ff; // pulls data line low when high
   reg [7:0] page_ff; // tx_page_select
   reg ctl_wr_ff; // one-cycle write strobe to paged blocks
   reg [7:0] ctl_wdata_ff; // data carried by that strobe
   wire [8*`CTPC_NUM_TX-1:0] ctl_vec; // all blocks' control bytes
   wire [7:0] ctl_sel; // control byte of read-selected block
   reg [7:0] rd_val; // read mux output

   // paged reads come from the block chosen by the read-select bit
   assign ctl_sel = ctl_vec[8*page_ff[`CTPC_PAGE_RDSEL] +: 8]; // RQ1 RQ4

   // read mux; unmapped offsets read as zero
   always @* begin
      if (ptr_ff == `CTPC_PAGE_OFF) begin
         rd_val = page_ff;
      end else if (ptr_ff == `CTPC_CTL_OFF) begin
         rd_val = ctl_sel; // RQ4
      end else begin
         rd_val = 8'h00;
      end
   end

   // byte-level protocol; start and stop override any state
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         i2c_st_ff <= ST_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         rw_ff <= 1'b0;
         ptr_pending_ff <= 1'b0;
         ptr_ff <= 8'h00;
         sda_oe_ff <= 1'b0;
         page_ff <= `CTPC_PAGE_RST;
         ctl_wr_ff <= 1'b0;
         ctl_wdata_ff <= 8'h00;
      end else begin
         ctl_wr_ff <= 1'b0;
         if (bus_start) begin
            // repeated start keeps the pointer for a following read
            i2c_st_ff <= ST_ADDR;
            bit_cnt_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
         end else if (bus_stop) begin
            i2c_st_ff <= ST_IDLE;
            sda_oe_ff <= 1'b0;
         end else if (scl_rise) begin
            // sample data on rising clock while receiving
            if (i2c_st_ff == ST_ADDR || i2c_st_ff == ST_WR) begin
               shift_ff <= {shift_ff[6:0], sda_ff[1]};
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (i2c_st_ff == ST_MACK) begin
               if (sda_ff[1]) begin
                  i2c_st_ff <= ST_IDLE; // nack ends the read
               end else begin
                  ptr_ff <= ptr_ff + 8'h01;
               end
            end
         end else if (scl_fall) begin
            // change data only while the clock is low
            case (i2c_st_ff)
               ST_ADDR: begin
                  if (bit_cnt_ff == 4'h8) begin
                     if (shift_ff[7:1] == I2C_ADDR) begin
                        rw_ff <= shift_ff[0];
                        sda_oe_ff <= 1'b1;
                        i2c_st_ff <= ST_ACKA;
                     end else begin
                        i2c_st_ff <= ST_IDLE; // not for us
                     end
                  end
               end
               ST_ACKA: begin
                  bit_cnt_ff <= 4'h0;
                  if (rw_ff) begin
                     shift_ff <= rd_val;
                     sda_oe_ff <= ~rd_val[7];
                     i2c_st_ff <= ST_RD;
                  end else begin
                     sda_oe_ff <= 1'b0;
                     ptr_pending_ff <= 1'b1;
                     i2c_st_ff <= ST_WR;
                  end
               end
               ST_WR: begin
                  if (bit_cnt_ff == 4'h8) begin
                     sda_oe_ff <= 1'b1;
                     i2c_st_ff <= ST_ACKW;
                     ptr_pending_ff <= 1'b0;
                     if (ptr_pending_ff) begin
                        ptr_ff <= shift_ff;
                     end else begin
                        ptr_ff <= ptr_ff + 8'h01;
                        if (ptr_ff == `CTPC_PAGE_OFF) begin
                           page_ff <= shift_ff & `CTPC_PAGE_WMASK;
                        end else if (ptr_ff == `CTPC_CTL_OFF) begin
                           // fan out to blocks; gating happens there
                           ctl_wr_ff <= 1'b1; // RQ4
                           ctl_wdata_ff <= shift_ff & `CTPC_CTL_WMASK;
                        end
                     end
                  end
               end
               ST_ACKW: begin
                  sda_oe_ff <= 1'b0;
                  bit_cnt_ff <= 4'h0;
                  i2c_st_ff <= ST_WR;
               end
               ST_RD: begin
                  if (bit_cnt_ff == 4'h7) begin
                     sda_oe_ff <= 1'b0; // release for controller ack
                     i2c_st_ff <= ST_MACK;
                  end else begin
                     shift_ff <= {shift_ff[6:0], 1'b0};
                     sda_oe_ff <= ~shift_ff[6];
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
               end
               ST_MACK: begin
                  // pointer already advanced on the ack edge
                  shift_ff <= rd_val;
                  sda_oe_ff <= ~rd_val[7];
                  bit_cnt_ff <= 4'h0;
                  i2c_st_ff <= ST_RD;
               end
               default: begin
                  sda_oe_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   // open drain: only ever pulls low
   assign o_sda_out = 1'b0;
   assign o_sda_oe = sda_oe_ff;

   // ===================================================================
   // per-transmitter control and sequencing
   localparam [1:0] TX_OFF = 2'h0; // output disabled
   localparam [1:0] TX_CAL = 2'h1; // sending skew calibration
   localparam [1:0] TX_RUN = 2'h2; // high-speed data allowed

   genvar gi;
   generate
      for (gi = 0; gi < `CTPC_NUM_TX; gi = gi + 1) begin : g_tx
         reg [7:0] ctl_ff; // tx_control for this block
         reg [1:0] tx_st_ff; // sequencing state
         reg first_pkt_ff; // a packet has gone out since enable
         reg on_ff; // output switched on
         reg cal_ff; // calibration sequence requested
         reg hs_ff; // high-speed data permitted
         reg [3:0] lane_ff; // active data lanes, bit per lane
         reg lpd_ff; // data lanes held in lp00
         reg lpc_ff; // clock lane held in lp00
         reg cont_ff; // clock lane continuous
         wire [1:0] lane_code;
         wire [1:0] lp_code;
         wire en;

         assign lane_code = ctl_ff[`CTPC_CTL_LANE_HI:`CTPC_CTL_LANE_LO];
         assign lp_code = ctl_ff[`CTPC_CTL_LP_HI:`CTPC_CTL_LP_LO];
         assign en = ctl_ff[`CTPC_CTL_EN];
         assign ctl_vec[8*gi +: 8] = ctl_ff;

         // shared strobe lands in every write-enabled block at once
         always @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
               ctl_ff <= `CTPC_CTL_RST;
            end else if (ctl_wr_ff && page_ff[gi]) begin // RQ2 RQ3
               ctl_ff <= ctl_wdata_ff;
            end
         end

         // enable, calibration then data; the host is expected to
         // have stopped forwarding before toggling enable
         always @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
               tx_st_ff <= TX_OFF;
               first_pkt_ff <= 1'b0;
            end else begin
               case (tx_st_ff)
                  TX_OFF: begin
                     first_pkt_ff <= 1'b0;
                     if (en) begin // RQ10
                        if (ctl_ff[`CTPC_CTL_CAL]) begin
                           tx_st_ff <= TX_CAL; // RQ5
                        end else begin
                           tx_st_ff <= TX_RUN;
                        end
                     end
                  end
                  TX_CAL: begin
                     if (!en) begin
                        tx_st_ff <= TX_OFF;
                     end else if (i_cal_done[gi]) begin
                        tx_st_ff <= TX_RUN; // RQ5
                     end
                  end
                  TX_RUN: begin
                     if (!en) begin
                        tx_st_ff <= TX_OFF;
                     end else if (i_pkt_sent[gi]) begin
                        first_pkt_ff <= 1'b1; // RQ9
                     end
                  end
                  default: begin
                     tx_st_ff <= TX_OFF;
                  end
               endcase
            end
         end

         // registered lane and mode outputs
         always @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
               on_ff <= 1'b0;
               cal_ff <= 1'b0;
               hs_ff <= 1'b0;
               lane_ff <= 4'h0;
               lpd_ff <= 1'b0;
               lpc_ff <= 1'b0;
               cont_ff <= 1'b0;
            end else begin
               on_ff <= en; // RQ10
               cal_ff <= (tx_st_ff == TX_CAL); // RQ5
               hs_ff <= (tx_st_ff == TX_RUN) && en; // RQ5
               // code picks how many low lanes carry data
               if (lane_code == 2'h0) begin
                  lane_ff <= 4'hf; // RQ7
               end else if (lane_code == 2'h1) begin
                  lane_ff <= 4'h7; // RQ7
               end else if (lane_code == 2'h2) begin
                  lane_ff <= 4'h3; // RQ7
               end else begin
                  lane_ff <= 4'h1; // RQ7
               end
               // reserved code falls through as normal operation
               lpd_ff <= (lp_code == `CTPC_LP_DATA) ||
                         (lp_code == `CTPC_LP_ALL); // RQ8 RQ12
               lpc_ff <= (lp_code == `CTPC_LP_ALL); // RQ8 RQ12
               // gated by first packet so startup is not disturbed
               cont_ff <= ctl_ff[`CTPC_CTL_CONT] && first_pkt_ff; // RQ9
            end
         end

         assign o_tx_on[gi] = on_ff;
         assign o_skew_cal[gi] = cal_ff;
         assign o_hs_ok[gi] = hs_ff;
         assign o_lane_en[4*gi +: 4] = lane_ff;
         assign o_lp00_data[gi] = lpd_ff;
         assign o_lp00_clk[gi] = lpc_ff;
         assign o_cont_clk[gi] = cont_ff;
      end
   endgenerate

endmodule // ctpc_top
`default_nettype wire

/* File: bench/ctpc_top_sva.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ctpc_defines.vh"
// ====
// port checker for the transmitter control block
module ctpc_top_sva (
   input wire i_core_clk,
   input wire i_arst_n,
   input wire i_scl,
   input wire o_sda_oe,
   input wire [`CTPC_NUM_TX-1:0] o_tx_on,
   input wire [`CTPC_NUM_TX-1:0] o_skew_cal,
   input wire [`CTPC_NUM_TX-1:0] o_hs_ok,
   input wire [4*`CTPC_NUM_TX-1:0] o_lane_en,
   input wire [`CTPC_NUM_TX-1:0] o_lp00_data,
   input wire [`CTPC_NUM_TX-1:0] o_lp00_clk,
   input wire [`CTPC_NUM_TX-1:0] o_cont_clk
);
   // one domain, async reset disables all
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_arst_n);
   // ====
   // lane and low-power fields
   property p_lp_clk0;
      o_lp00_clk[0] |-> o_lp00_data[0];
   endproperty
   a_lp_clk0: assert property (p_lp_clk0) else $error("clock forced alone");
   property p_lp_clk1;
      o_lp00_clk[1] |-> o_lp00_data[1];
   endproperty
   a_lp_clk1: assert property (p_lp_clk1) else $error("clock forced alone");
   property p_lanes;
      o_lane_en[3:0] inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
   endproperty
   a_lanes: assert property (p_lanes) else $error("bad lane mask");
   // ====
   // sequencing of calibration, data and clock
   property p_cal_no_hs;
      o_skew_cal[0] |-> !o_hs_ok[0];
   endproperty
   a_cal_no_hs: assert property (p_cal_no_hs) else $error("data in cal");
   property p_hs_on;
      $rose(o_hs_ok[0]) |-> o_tx_on[0];
   endproperty
   a_hs_on: assert property (p_hs_on) else $error("data while off");
   property p_off;
      $fell(o_tx_on[0]) |-> ##[0:2] (!o_hs_ok[0] && !o_skew_cal[0]);
   endproperty
   a_off: assert property (p_off) else $error("output did not stop");
   property p_cont_first;
      $rose(o_hs_ok[0]) |-> !o_cont_clk[0];
   endproperty
   a_cont_first: assert property (p_cont_first) else $error("clock early");
   property p_cont_run;
      $rose(o_cont_clk[0]) |-> o_hs_ok[0];
   endproperty
   a_cont_run: assert property (p_cont_run) else $error("clock not in run");
   // ack and read bits start pulling low only while the bus clock is low
   property p_ack_low;
      $rose(o_sda_oe) |-> !i_scl;
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("data moved, clk high");
   // main scenarios reached
   c_cal: cover property ($rose(o_skew_cal[0]));
   c_cont: cover property ($rose(o_cont_clk[0]));
   c_lp: cover property (o_lp00_clk[1]);
endmodule // ctpc_top_sva
`default_nettype wire

/* File: bench/ctpc_phy_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ====
// far-side receiver: trains during calibration, flags a sent packet every 16 high-speed cycles
module ctpc_phy_model (
   input wire logic i_clk,
   input wire logic i_slow,
   input wire logic [1:0] i_skew_cal,
   input wire logic [1:0] i_hs_ok,
   output logic [1:0] o_cal_done,
   output logic [1:0] o_pkt_sent
);
   int cnt [2] = '{0, 0}; // per-block cycle counter, one driver only
   // training length depends on pace; packets only in high speed
   always @(posedge i_clk) begin
      for (int b = 0; b < 2; b++) begin
         o_cal_done[b] <= 1'b0;
         o_pkt_sent[b] <= 1'b0;
         if (i_skew_cal[b]) begin
            cnt[b] <= cnt[b] + 1;
            if (cnt[b] >= (i_slow ? 300 : 40)) begin
               o_cal_done[b] <= 1'b1;
               cnt[b] <= 0;
            end
         end else if (i_hs_ok[b]) begin
            cnt[b] <= cnt[b] + 1;
            o_pkt_sent[b] <= (cnt[b] % 16 == 15);
         end else begin
            cnt[b] <= 0;
         end
      end
   end
endmodule // ctpc_phy_model
`default_nettype wire

/* File: bench/csi2_tx_port_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ctpc_defines.vh"
// ====
// bench: bus master at 48 ns bus clock, receiver model
module csi2_tx_port_control_tb;
   localparam logic [6:0] DEV = 7'h30; // bench target address
   logic clk = 1'b0; // core clock
   logic arst_n = 1'b0; // async reset
   logic scl = 1'b1; // bus clock idles high, still between frames
   logic sda_m = 1'b1; // master drive, high = released
   logic slow = 1'b0; // partner training pace
   wire sda_oe, sda_out, sda_w;
   wire [1:0] cal_done, pkt_sent, tx_on, skew_cal, hs_ok, lp_d, lp_c, cont;
   wire [7:0] lane_en;
   int error_cnt = 0;
   int comparisons = 0;
   logic [7:0] rd;
   logic [7:0] v;
   // pull-up wins unless someone pulls low
   assign sda_w = (sda_oe ? sda_out : 1'b1) & sda_m;
   always #2.5 clk = ~clk;
   ctpc_top #(.I2C_ADDR(DEV)) dut (.i_core_clk(clk), .i_arst_n(arst_n),
      .i_scl(scl), .i_sda_in(sda_w), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
      .i_cal_done(cal_done), .i_pkt_sent(pkt_sent), .o_tx_on(tx_on),
      .o_skew_cal(skew_cal), .o_hs_ok(hs_ok), .o_lane_en(lane_en),
      .o_lp00_data(lp_d), .o_lp00_clk(lp_c), .o_cont_clk(cont));
   ctpc_phy_model u_phy (.i_clk(clk), .i_slow(slow), .i_skew_cal(skew_cal),
      .i_hs_ok(hs_ok), .o_cal_done(cal_done), .o_pkt_sent(pkt_sent));
   // ====
   // expectations and compares
   function automatic logic [3:0] f_lanes(input logic [1:0] c);
      return 4'hf >> c;
   endfunction
   function automatic logic [3:0] f_lp(input logic [1:0] c);
      return {2'h0, c == 2'h3, c == 2'h1 || c == 2'h3}; // reserved: none
   endfunction
   task automatic chk_reg(input string n, input logic [7:0] e, g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_pin(input string n, input logic [3:0] e, g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // ====
   // bus cycles; times avoid rising core clock edges
   task automatic bx(input logic b, output logic r);
      #12 sda_m = b;
      #12 scl = 1'b1;
      #12 r = sda_w;
      #12 scl = 1'b0;
   endtask
   task automatic st(); // start or repeated start
      if (scl === 1'b0) begin
         #12 sda_m = 1'b1;
         #12 scl = 1'b1;
      end
      #12 sda_m = 1'b0;
      #12 scl = 1'b0;
   endtask
   task automatic sp();
      #12 sda_m = 1'b0;
      #12 scl = 1'b1;
      #12 sda_m = 1'b1;
      #12;
   endtask
   task automatic wb(input logic [7:0] d, input logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bx(d[i], r);
      bx(1'b1, r);
      chk_pin("ack", {3'h0, ack}, {3'h0, ~r});
   endtask
   task automatic reg_wr(input logic [7:0] a, d);
      st();
      wb({DEV, 1'b0}, 1'b1);
      wb(a, 1'b1);
      wb(d, 1'b1);
      sp();
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      logic r;
      st();
      wb({DEV, 1'b0}, 1'b1);
      wb(a, 1'b1);
      st();
      wb({DEV, 1'b1}, 1'b1);
      for (int i = 7; i >= 0; i--) bx(1'b1, d[i]);
      bx(1'b1, r); // nack ends the read
      sp();
   endtask
   task automatic conclude();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // watchdog: whole run needs well under 20k cycles
   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      conclude();
   end
   // ====
   // main sequence
   initial begin
      v = $urandom(60396);
      repeat (8) @(posedge clk);
      @(negedge clk) arst_n = 1'b1;
      repeat (10) @(negedge clk);
      reg_rd(8'h33, rd);
      chk_reg("ctl reset", 8'h00, rd);
      reg_wr(8'h32, 8'hff);
      reg_rd(8'h32, rd);
      chk_reg("page mask", 8'h13, rd);
      reg_wr(8'h32, 8'h10); // reads block 1, writes off
      reg_wr(8'h33, 8'h55);
      reg_rd(8'h33, rd);
      chk_reg("gated", 8'h00, rd);
      reg_wr(8'h32, 8'h12); // only block 1 written
      reg_wr(8'h33, 8'hb1);
      reg_rd(8'h33, rd);
      chk_reg("blk1", 8'h31, rd);
      chk_pin("blk1 only", 4'h2, {2'h0, tx_on});
      reg_wr(8'h32, 8'h03); // both blocks, read block 0
      for (int i = 0; i < 16; i++) begin
         v = 8'($urandom);
         v = {v[7], 1'b0, i[3:0], v[1], 1'b1};
         reg_wr(8'h33, v);
         reg_rd(8'h33, rd);
         chk_reg("ctl", {1'b0, v[6:0]}, rd);
         for (int b = 0; b < 2; b++) begin
            chk_pin("lanes", f_lanes(v[5:4]), lane_en[4*b+:4]);
            chk_pin("lp", f_lp(v[3:2]), {2'h0, lp_c[b], lp_d[b]});
            chk_pin("on", {2'h0, v[1], 1'b1}, {2'h0, cont[b], tx_on[b]});
         end
      end
      reg_wr(8'h34, v); // unmapped
      reg_rd(8'h34, rd);
      chk_reg("unmapped", 8'h00, rd);
      st();
      wb({7'h31, 1'b0}, 1'b0); // other address refused
      sp();
      reg_wr(8'h32, 8'h01);
      for (int s = 1; s >= 0; s--) begin
         slow = s[0];
         reg_wr(8'h33, 8'h00); // forwarding assumed off
         chk_pin("off", 4'h0, {2'h0, hs_ok[0], tx_on[0]});
         reg_wr(8'h33, 8'h43); // calibrate at top rate
         chk_pin("cal", 4'h1, {1'h0, cont[0], hs_ok[0], skew_cal[0]});
         for (int n = 0; n < 1000 && hs_ok[0] !== 1'b1; n++) @(negedge clk);
         chk_pin("run", 4'h2, {1'h0, cont[0], hs_ok[0], skew_cal[0]});
         for (int n = 0; n < 60 && cont[0] !== 1'b1; n++) @(negedge clk);
         chk_pin("cont", 4'h1, {3'h0, cont[0]});
      end
      conclude();
   end
endmodule // csi2_tx_port_control_tb
bind ctpc_top ctpc_top_sva u_sva (.i_core_clk(i_core_clk),
   .i_arst_n(i_arst_n), .i_scl(i_scl), .o_sda_oe(o_sda_oe),
   .o_tx_on(o_tx_on), .o_skew_cal(o_skew_cal), .o_hs_ok(o_hs_ok),
   .o_lane_en(o_lane_en), .o_lp00_data(o_lp00_data),
   .o_lp00_clk(o_lp00_clk), .o_cont_clk(o_cont_clk));
`default_nettype wire
